// ==== dv/dm_model.sv ====
`timescale 1ns/1ps
module dm_model (
	// clock
	input  wire logic                            clk,
	// data memory port
	input  wire logic [addlogic_pkg::ADDR_W-1:0] dm_addr_q,
	input  wire logic                            dm_rd_en_q,
	input  wire logic                            dm_wr_en_q,
	input  wire logic [addlogic_pkg::DATA_W-1:0] dm_wdata_q,
	output logic      [addlogic_pkg::DATA_W-1:0] dm_rdata
);
	logic [7:0] mem [256];

	initial dm_rdata = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// read data is good for one cycle only; it flips otherwise so stale data shows
	always @(posedge clk) begin
		if (dm_wr_en_q) begin
			mem[dm_addr_q] <= dm_wdata_q;
		end
		if (dm_rd_en_q) begin
			dm_rdata <= mem[dm_addr_q];
		end else begin
			dm_rdata <= ~dm_rdata;
		end
	end
endmodule // dm_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [1:0]  op_code = 2'h0;
	logic [7:0]  op_addr = 8'h00, op_imm = 8'h00, op_result_q, dm_addr_q, dm_rdata, dm_wdata_q;
	logic        op_ready_q, op_done_q, dm_rd_en_q, dm_wr_en_q, avs_waitrequest;
	logic [3:0]  avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [7:0]  w, r;
	logic [4:0]  fl;
	logic [8:0]  s;
	int          num_errors = 0, n_tests = 0, n_ops = 0;

	always #4 clk = ~clk;

	add_and_logic_ops dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
		.op_addr(op_addr), .op_imm(op_imm), .op_ready_q(op_ready_q), .op_done_q(op_done_q),
		.op_result_q(op_result_q), .dm_addr_q(dm_addr_q), .dm_rd_en_q(dm_rd_en_q),
		.dm_rdata(dm_rdata), .dm_wr_en_q(dm_wr_en_q), .dm_wdata_q(dm_wdata_q),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	dm_model mem_i (.clk(clk), .dm_addr_q(dm_addr_q), .dm_rd_en_q(dm_rd_en_q),
		.dm_wr_en_q(dm_wr_en_q), .dm_wdata_q(dm_wdata_q), .dm_rdata(dm_rdata));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one avalon cycle; read data lands in rd
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		k = 0;
		do begin @(posedge clk); k++; end while (avs_waitrequest !== 1'b0 && k < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 20) begin num_errors++; final_report(); end
	endtask

	task automatic setw(input logic [7:0] wv, input logic [4:0] fv);
		bus(1'b1, addlogic_pkg::OFF_WORK, {24'h0, wv});
		bus(1'b1, addlogic_pkg::OFF_FLAGS, {27'h0, fv});
		w = wv;
		fl = fv;
	endtask

	// predict one op, issue it, then judge result, work, flags and memory
	task automatic run(input logic [1:0] c, input logic [7:0] a, input logic [7:0] x);
		logic [7:0] m;
		int k;
		m = mem_i.mem[a];
		s = {1'b0, w} + {1'b0, m};
		r = (c == 2'h0) ? s[7:0] : (c == 2'h2) ? (w & x) : (w & m);
		if (c == 2'h0) begin
			fl = {(w[7] == m[7] && s[7] != w[7]) ^ s[7], w[7] == m[7] && s[7] != w[7],
				s[7:0] == 8'h00, ({1'b0, w[3:0]} + {1'b0, m[3:0]}) > 5'h0f, s[8]};
		end else begin
			fl[addlogic_pkg::FL_RESULT_NULL] = (r == 8'h00);
		end
		if (c == 2'h1 || c == 2'h2) w = r;
		@(posedge clk);
		op_code <= c;
		op_addr <= a;
		op_imm <= x;
		op_valid <= 1'b1;
		k = 0;
		do begin @(posedge clk); k++; end while (op_ready_q !== 1'b1 && k < 20);
		op_valid <= 1'b0;
		do begin @(posedge clk); k++; end while (op_done_q !== 1'b1 && k < 40);
		if (k >= 40) begin num_errors++; final_report(); end
		n_ops++;
		check({24'h0, op_result_q}, {24'h0, r});
		bus(1'b0, addlogic_pkg::OFF_WORK, 32'h0);
		check(rd, {24'h0, w});
		bus(1'b0, addlogic_pkg::OFF_FLAGS, 32'h0);
		check(rd, {27'h0, fl});
		check({24'h0, mem_i.mem[a]}, {24'h0, (c[0] == c[1]) ? r : m});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check({30'h0, op_ready_q, op_done_q}, 32'h2);
		bus(1'b0, 4'h0, 32'h0);
		check(rd, {24'h0, addlogic_pkg::WORK_RST});
		bus(1'b0, 4'h4, 32'h0);
		check(rd, {27'h0, addlogic_pkg::FLAGS_RST});
		bus(1'b0, 4'h8, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 4'hc, 32'h5a5a_5a5a);
		bus(1'b0, 4'hc, 32'h0);
		check(rd, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_add();
		logic [7:0] wa [4] = '{8'h7f, 8'hff, 8'h80, 8'h12};
		logic [7:0] ma [4] = '{8'h01, 8'h01, 8'h80, 8'h34};
		for (int i = 0; i < 4; i++) begin
			mem_i.mem[8'h10 + i] = ma[i];
			setw(wa[i], 5'h00);
			run(2'h0, 8'(8'h10 + i), 8'h00);
		end
		$display("test add done");
	endtask

	task automatic t_and();
		mem_i.mem[8'h20] = 8'h0f;
		mem_i.mem[8'h21] = 8'hff;
		setw(8'hf0, 5'h1b);
		run(2'h1, 8'h20, 8'h00);
		run(2'h1, 8'h21, 8'h00);
		setw(8'ha5, 5'h1b);
		run(2'h2, 8'h20, 8'h5a);
		setw(8'ha5, 5'h1f);
		run(2'h2, 8'h20, 8'hff);
		mem_i.mem[8'h30] = 8'hf0;
		mem_i.mem[8'hff] = 8'hc3;
		setw(8'h3c, 5'h1b);
		run(2'h3, 8'h30, 8'h00);
		run(2'h3, 8'hff, 8'h00);
		$display("test and done");
	endtask

	// status read while a memory op is in flight must show busy
	task automatic t_busy();
		mem_i.mem[8'h40] = 8'h5c;
		setw(8'h6e, 5'h00);
		@(posedge clk);
		op_code <= 2'h3;
		op_addr <= 8'h40;
		op_valid <= 1'b1;
		@(posedge clk);
		check({31'h0, op_ready_q}, 32'h1);
		op_valid <= 1'b0;
		bus(1'b0, addlogic_pkg::OFF_STATUS, 32'h0);
		check(rd, {16'h0, n_ops[7:0], 8'h01});
		n_ops++;
		repeat (2) @(posedge clk);
		check({24'h0, mem_i.mem[8'h40]}, {24'h0, 8'h4c});
		$display("test busy done");
	endtask

	task automatic t_count();
		bus(1'b0, addlogic_pkg::OFF_STATUS, 32'h0);
		check(rd, {16'h0, n_ops[7:0], 8'h00});
		$display("test count done");
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_add();
		t_and();
		t_busy();
		t_count();
		final_report();
	end
endmodule // tb_top

// ==== src/add_and_logic_ops.sv ====
`timescale 1ns/1ps
module add_and_logic_ops (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rstn,
	// instruction from decoder
	input  wire logic                            op_valid,
	input  wire logic [1:0]                      op_code,
	input  wire logic [addlogic_pkg::ADDR_W-1:0] op_addr,
	input  wire logic [addlogic_pkg::DATA_W-1:0] op_imm,
	output logic                                 op_ready_q,
	output logic                                 op_done_q,
	output logic [addlogic_pkg::DATA_W-1:0]      op_result_q,
	// data memory
	output logic [addlogic_pkg::ADDR_W-1:0]      dm_addr_q,
	output logic                                 dm_rd_en_q,
	input  wire logic [addlogic_pkg::DATA_W-1:0] dm_rdata,
	output logic                                 dm_wr_en_q,
	output logic [addlogic_pkg::DATA_W-1:0]      dm_wdata_q,
	// avalon-mm slave
	input  wire logic [addlogic_pkg::BUS_AW-1:0] avs_address,
	input  wire logic                            avs_read,
	input  wire logic                            avs_write,
	input  wire logic [31:0]                     avs_writedata,
	output logic [31:0]                          avs_readdata,
	output logic                                 avs_waitrequest
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic reads_mem(input logic [1:0] op);
		reads_mem = (op != addlogic_pkg::OP_AND_IMM_TO_WR);
	endfunction

	function automatic logic writes_mem(input logic [1:0] op);
		writes_mem = (op == addlogic_pkg::OP_ADD_TO_MEMORY) ||
			(op == addlogic_pkg::OP_AND_INTO_MEM);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	addlogic_pkg::exec_state_t              state_q;
	addlogic_pkg::exec_state_t              state_d;
	logic [1:0]                             op_q;
	logic [addlogic_pkg::DATA_W-1:0]        imm_q;
	logic [addlogic_pkg::DATA_W-1:0]        work_register_q;
	logic [addlogic_pkg::FLAG_W-1:0]        flags_q;
	logic [7:0]                             op_count_q;
	logic                                   accept;
	logic                                   bus_wr;
	logic [addlogic_pkg::DATA_W-1:0]        operand_b;
	logic [addlogic_pkg::DATA_W:0]          sum9;
	logic [4:0]                             nib5;
	logic [addlogic_pkg::DATA_W-1:0]        result;
	logic                                   signed_range_flag;

	assign accept = op_valid && op_ready_q;
	assign bus_wr = avs_write && !avs_waitrequest;

	////////////////////////////////////////////////////////////////////////////////
	// arithmetic and logic

	always_comb begin
		operand_b = (op_q == addlogic_pkg::OP_AND_IMM_TO_WR) ? imm_q : dm_rdata;
		sum9      = {1'b0, work_register_q} + {1'b0, operand_b};
		nib5      = {1'b0, work_register_q[3:0]} + {1'b0, operand_b[3:0]};
		signed_range_flag = (work_register_q[7] == operand_b[7]) &&
			(sum9[7] != work_register_q[7]);
		if (op_q == addlogic_pkg::OP_ADD_TO_MEMORY) begin
			result = sum9[addlogic_pkg::DATA_W-1:0];
		end else begin
			result = work_register_q & operand_b;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencing

	always_comb begin
		state_d = state_q;
		case (state_q)
			addlogic_pkg::ST_IDLE: begin
				if (accept) begin
					state_d = reads_mem(op_code) ? addlogic_pkg::ST_READ : addlogic_pkg::ST_EXEC;
				end
			end
			addlogic_pkg::ST_READ: state_d = addlogic_pkg::ST_EXEC;
			addlogic_pkg::ST_EXEC: state_d = addlogic_pkg::ST_IDLE;
			default:               state_d = addlogic_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q    <= addlogic_pkg::ST_IDLE;
			op_ready_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			op_ready_q <= (state_d == addlogic_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_q      <= 2'h0;
			imm_q     <= 8'h00;
			dm_addr_q <= 8'h00;
		end else if (accept) begin
			op_q      <= op_code;
			imm_q     <= op_imm;
			dm_addr_q <= op_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data memory port

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dm_rd_en_q <= 1'b0;
			dm_wr_en_q <= 1'b0;
			dm_wdata_q <= 8'h00;
		end else begin
			dm_rd_en_q <= (state_d == addlogic_pkg::ST_READ);
			// only the two memory-destined ops write back
			dm_wr_en_q <= (state_q == addlogic_pkg::ST_EXEC) && writes_mem(op_q);
			if (state_q == addlogic_pkg::ST_EXEC) begin
				dm_wdata_q <= result;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// work register and flags; datapath wins over a bus write on the same edge

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			work_register_q <= addlogic_pkg::WORK_RST;
		end else if (state_q == addlogic_pkg::ST_EXEC && !writes_mem(op_q)) begin
			work_register_q <= result;
		end else if (bus_wr && avs_address == addlogic_pkg::OFF_WORK) begin
			work_register_q <= avs_writedata[addlogic_pkg::DATA_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= addlogic_pkg::FLAGS_RST;
		end else if (state_q == addlogic_pkg::ST_EXEC) begin
			flags_q[addlogic_pkg::FL_RESULT_NULL] <= (result == 8'h00);
			if (op_q == addlogic_pkg::OP_ADD_TO_MEMORY) begin
				flags_q[addlogic_pkg::FL_MSB_SPILL]    <= sum9[8];
				flags_q[addlogic_pkg::FL_NIBBLE_SPILL] <= nib5[4];
				flags_q[addlogic_pkg::FL_SIGNED_RANGE] <= signed_range_flag;
				flags_q[addlogic_pkg::FL_SIGNED_SPILL] <= signed_range_flag ^ sum9[7];
			end
		end else if (bus_wr && avs_address == addlogic_pkg::OFF_FLAGS) begin
			flags_q <= avs_writedata[addlogic_pkg::FLAG_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_done_q   <= 1'b0;
			op_result_q <= 8'h00;
			op_count_q  <= addlogic_pkg::COUNT_RST;
		end else begin
			op_done_q <= (state_q == addlogic_pkg::ST_EXEC);
			if (state_q == addlogic_pkg::ST_EXEC) begin
				op_result_q <= result;
				op_count_q  <= op_count_q + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: request seen at edge 1, answered with waitrequest low at edge 2

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				addlogic_pkg::OFF_WORK:   avs_readdata <= {24'h00_0000, work_register_q};
				addlogic_pkg::OFF_FLAGS:  avs_readdata <= {27'h000_0000, flags_q};
				addlogic_pkg::OFF_STATUS: avs_readdata <= {16'h0000, op_count_q, 7'h00,
					(state_q != addlogic_pkg::ST_IDLE)};
				default:                  avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic exec_now;
	assign exec_now = (state_q == addlogic_pkg::ST_EXEC);

	a_add_mem_write: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_ADD_TO_MEMORY |=>
		dm_wr_en_q && dm_wdata_q == $past(work_register_q) + $past(dm_rdata))
		else $error("sum not written back to memory");

	a_add_flag_set: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_ADD_TO_MEMORY |=>
		flags_q[addlogic_pkg::FL_MSB_SPILL] ==
		(({1'b0, $past(work_register_q)} + {1'b0, $past(dm_rdata)}) > 9'h0ff) &&
		flags_q[addlogic_pkg::FL_NIBBLE_SPILL] ==
		(({1'b0, $past(work_register_q[3:0])} + {1'b0, $past(dm_rdata[3:0])}) > 5'h0f) &&
		flags_q[addlogic_pkg::FL_SIGNED_RANGE] ==
		($past(work_register_q[7]) == $past(dm_rdata[7]) &&
		dm_wdata_q[7] != $past(work_register_q[7])) &&
		flags_q[addlogic_pkg::FL_SIGNED_SPILL] ==
		(flags_q[addlogic_pkg::FL_SIGNED_RANGE] ^ dm_wdata_q[7]) &&
		flags_q[addlogic_pkg::FL_RESULT_NULL] == (dm_wdata_q == 8'h00))
		else $error("add flags wrong");

	a_and_mem_wr: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_MEM_TO_WR |=>
		work_register_q == ($past(work_register_q) & $past(dm_rdata)) &&
		{flags_q[4:3], flags_q[1:0]} == {$past(flags_q[4:3]), $past(flags_q[1:0])} &&
		flags_q[addlogic_pkg::FL_RESULT_NULL] == (work_register_q == 8'h00))
		else $error("memory AND result or flags wrong");

	a_and_no_memwr: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && !writes_mem(op_q) |=> !dm_wr_en_q ##1 !dm_wr_en_q)
		else $error("AND to work register wrote memory");

	a_and_imm_res: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_IMM_TO_WR |=>
		work_register_q == ($past(work_register_q) & $past(imm_q)) &&
		{flags_q[4:3], flags_q[1:0]} == {$past(flags_q[4:3]), $past(flags_q[1:0])})
		else $error("immediate AND wrong");

	a_and_into_mem: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_INTO_MEM |=>
		dm_wr_en_q && dm_addr_q == $past(dm_addr_q) &&
		dm_wdata_q == ($past(dm_rdata) & $past(work_register_q)))
		else $error("AND into memory wrong");

	a_null_flag: assert property (@(posedge clk) disable iff (!rstn)
		op_done_q |-> flags_q[addlogic_pkg::FL_RESULT_NULL] == (op_result_q == 8'h00))
		else $error("null flag does not match result");

	a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
		(avs_read || avs_write) && avs_waitrequest |-> ##1 !avs_waitrequest)
		else $error("bus not answered in one cycle");

	a_mem_op_keep: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && writes_mem(op_q) &&
		!(bus_wr && avs_address == addlogic_pkg::OFF_WORK) |=>
		work_register_q == $past(work_register_q))
		else $error("memory op changed work register");

	a_and_into_memory_op_flag_keep: assert property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_INTO_MEM |=>
		{flags_q[4:3], flags_q[1:0]} == {$past(flags_q[4:3]), $past(flags_q[1:0])} &&
		flags_q[addlogic_pkg::FL_RESULT_NULL] == ($past(dm_rdata & work_register_q) == 8'h00))
		else $error("AND into memory flags wrong");

	a_read_pulse: assert property (@(posedge clk) disable iff (!rstn)
		dm_rd_en_q |=> !dm_rd_en_q)
		else $error("memory read longer than one cycle");

	a_write_pulse: assert property (@(posedge clk) disable iff (!rstn)
		dm_wr_en_q |=> !dm_wr_en_q)
		else $error("memory write longer than one cycle");

	a_done_ready: assert property (@(posedge clk) disable iff (!rstn)
		op_done_q |-> op_ready_q)
		else $error("done without ready");

	a_busy_not_ready: assert property (@(posedge clk) disable iff (!rstn)
		state_q != addlogic_pkg::ST_IDLE |-> !op_ready_q)
		else $error("ready while busy");

	a_mem_read_req: assert property (@(posedge clk) disable iff (!rstn)
		accept && reads_mem(op_code) |=>
		dm_rd_en_q && dm_addr_q == $past(op_addr))
		else $error("memory operand not requested");

	a_imm_no_read: assert property (@(posedge clk) disable iff (!rstn)
		accept && !reads_mem(op_code) |=>
		!dm_rd_en_q ##1 op_done_q)
		else $error("immediate AND read memory or was late");

	c_add_carry: cover property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_ADD_TO_MEMORY && sum9[8]);
	c_and_into_mem: cover property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_INTO_MEM ##1 dm_wr_en_q);
	c_status_read: cover property (@(posedge clk) disable iff (!rstn)
		avs_read && !avs_waitrequest && avs_address == addlogic_pkg::OFF_STATUS);
	c_and_imm: cover property (@(posedge clk) disable iff (!rstn)
		exec_now && op_q == addlogic_pkg::OP_AND_IMM_TO_WR && result == 8'h00);

endmodule // add_and_logic_ops

// ==== src/addlogic_pkg.sv ====
package addlogic_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int BUS_AW = 4;
	localparam int FLAG_W = 5;

	// register byte offsets
	localparam logic [BUS_AW-1:0] OFF_WORK   = 4'h0;
	localparam logic [BUS_AW-1:0] OFF_FLAGS  = 4'h4;
	localparam logic [BUS_AW-1:0] OFF_STATUS = 4'h8;

	// flag bit positions
	localparam int FL_MSB_SPILL    = 0;
	localparam int FL_NIBBLE_SPILL = 1;
	localparam int FL_RESULT_NULL  = 2;
	localparam int FL_SIGNED_RANGE = 3;
	localparam int FL_SIGNED_SPILL = 4;

	// status field positions
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_COUNT_LSB = 8;

	// values after reset
	localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
	localparam logic [7:0]        COUNT_RST = 8'h00;

	typedef enum logic [1:0] {
		OP_ADD_TO_MEMORY  = 2'h0,
		OP_AND_MEM_TO_WR  = 2'h1,
		OP_AND_IMM_TO_WR  = 2'h2,
		OP_AND_INTO_MEM   = 2'h3
	} op_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_READ = 3'h2,
		ST_EXEC = 3'h4
	} exec_state_t;

endpackage
